/* File: rtl/cps_core.sv */
`timescale 1ns/10ps
`include "cps_consts.svh"
// Operation
// - PC is 13 bits; its low byte is readable and writable.
// - PC bits 12..8 are hidden; no file or bus access reads or writes them directly.
// - Any reset clears the whole PC.
// - A low byte write loads PC upper bits from holding bits 4..0.
// - Call and jump take PC bits 12..11 from holding bits 4..3.
// - Return stack has eight 13-bit entries.
// - Stack is outside program and data space; pointer hidden.
// - Call pushes the PC; interrupt vectoring pushes the address of the replaced word.
// - Return, literal return and interrupt exit pop into the PC.
// - Push and pop leave the upper holding register alone.
// - Stack wraps circularly; ninth push overwrites the first.
// - No overflow or underflow flag exists.
// - Indirect port accesses the location chosen by the pointer.
// - Reading the port through itself returns zero.
// - Writing the port through itself stores nothing.
// - Effective address is bank bit then pointer; bank bit unused.
// - 8-bit ALU on accumulator and file or literal.
// - ALU sets carry, nibble carry, zero; borrow sense on subtract.
// - One 14-bit word fetched per cycle on its own bus.
// - Fetch overlaps execute; branches cost one extra cycle.
// - Program space is PROG_WORDS words, 2K by default, held outside the core.
module cps_core #(
  parameter int STACK_DEPTH = 8,
  parameter int DMEM_WORDS = 128,
  parameter int PROG_WORDS = 2048
) (
  input wire logic core_clk,
  input wire logic reset,
  output logic [12:0] prog_addr,
  input wire logic [13:0] prog_data,
  output logic [13:0] instr_word,
  output logic instr_valid,
  input wire cps_pkg::cps_op_e exec_op,
  input wire cps_pkg::cps_alu_e alu_op,
  input wire logic [7:0] op_file,
  input wire logic [7:0] op_lit,
  input wire logic op_use_lit,
  input wire logic op_to_file,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import cps_pkg::*;

  localparam int SPW = $clog2(STACK_DEPTH);
  localparam int DAW = $clog2(DMEM_WORDS);
  localparam int PAW = $clog2(PROG_WORDS);
  // Keeps the incremented fetch address inside program space for power-of-two sizes up to 13 bits
  localparam logic [12:0] PC_MASK = 13'((32'd1 << PAW) - 32'd1);

  // Whole state of the block
  typedef struct packed {
    logic [12:0] pc;
    logic [13:0] ir;
    logic ir_valid;
    logic [12:0] ir_pc;
    logic [7:0] w;
    logic [7:0] ptr;
    logic [4:0] uah;
    logic [7:0] status;
    logic [SPW-1:0] sp;
    logic [STACK_DEPTH-1:0][12:0] stack;
    logic [DMEM_WORDS-1:0][7:0] dmem;
    logic run;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cps_state_s;

  cps_state_s st_ff;
  cps_state_s nxt_st;

  // Resolve the indirect port through the pointer; bank bit ignored
  function automatic logic [7:0] eff_addr(cps_state_s s, logic [7:0] a);
    logic [8:0] e9;
    e9 = {s.status[`CPS_ST_BANK], s.ptr};
    eff_addr = (a == `CPS_F_IND) ? e9[7:0] : a;
  endfunction

  // Read one file register as an instruction sees it
  function automatic logic [7:0] file_rd(cps_state_s s, logic [7:0] a);
    logic [7:0] e;
    e = eff_addr(s, a);
    if (e == `CPS_F_IND) begin
      file_rd = 8'h00;
    end else if (e == `CPS_F_CLB) begin
      file_rd = s.pc[7:0];
    end else if (e == `CPS_F_STATUS) begin
      file_rd = s.status;
    end else if (e == `CPS_F_PTR) begin
      file_rd = s.ptr;
    end else if (e == `CPS_F_UAH) begin
      file_rd = {3'b000, s.uah};
    end else begin
      file_rd = s.dmem[e[DAW-1:0]];
    end
  endfunction

  // Write one file register; a low byte write is a branch
  function automatic cps_state_s file_wr(cps_state_s s, logic [7:0] a, logic [7:0] v);
    logic [7:0] e;
    file_wr = s;
    e = eff_addr(s, a);
    if (e == `CPS_F_IND) begin
      file_wr.dmem = s.dmem;
    end else if (e == `CPS_F_CLB) begin
      file_wr.pc = {s.uah, v};
      file_wr.ir_valid = 1'b0;
    end else if (e == `CPS_F_STATUS) begin
      file_wr.status = v;
    end else if (e == `CPS_F_PTR) begin
      file_wr.ptr = v;
    end else if (e == `CPS_F_UAH) begin
      file_wr.uah = v[4:0];
    end else begin
      file_wr.dmem[e[DAW-1:0]] = v;
    end
  endfunction

  // Stack pointer step with circular wrap and no overflow flag
  function automatic logic [SPW-1:0] sp_step(logic [SPW-1:0] p, logic up);
    if (up) begin
      sp_step = (p == SPW'(STACK_DEPTH - 1)) ? '0 : p + SPW'(1);
    end else begin
      sp_step = (p == '0) ? SPW'(STACK_DEPTH - 1) : p - SPW'(1);
    end
  endfunction

  // Top of stack and call target, shared with the checks
  logic [SPW-1:0] sp_prev;
  logic [12:0] stack_top;
  logic [12:0] call_tgt;
  logic exec_go;
  logic apb_wr;
  assign sp_prev = sp_step(st_ff.sp, 1'b0);
  assign stack_top = st_ff.stack[sp_prev];
  assign call_tgt = {st_ff.uah[4:3], st_ff.ir[10:0]};
  assign exec_go = st_ff.run && st_ff.ir_valid;
  assign apb_wr = psel && penable && st_ff.pready && pwrite && !st_ff.pslverr;

  // APB address decode
  cps_apb_e a_kind;
  logic [7:0] a_file;
  always_comb begin
    a_kind = APB_FILE;
    a_file = `CPS_F_IND;
    if (paddr == `CPS_A_CLB) begin
      a_file = `CPS_F_CLB;
    end else if (paddr == `CPS_A_UAH) begin
      a_file = `CPS_F_UAH;
    end else if (paddr == `CPS_A_PTR) begin
      a_file = `CPS_F_PTR;
    end else if (paddr == `CPS_A_STATUS) begin
      a_file = `CPS_F_STATUS;
    end else if (paddr == `CPS_A_IND) begin
      a_file = `CPS_F_IND;
    end else if (paddr == `CPS_A_ACC) begin
      a_kind = APB_ACC;
    end else if (paddr == `CPS_A_CTRL) begin
      a_kind = APB_CTRL;
    end else begin
      a_kind = APB_BAD;
    end
  end

  // Next state: fetch, then bus access, then execute (execute wins)
  always_comb begin
    logic [7:0] b;
    logic [7:0] wo;
    logic [8:0] s9;
    logic [4:0] n5;
    logic [7:0] res;
    logic sub;
    b = 8'h00;
    wo = 8'h00;
    s9 = 9'h000;
    n5 = 5'h00;
    res = 8'h00;
    sub = 1'b0;
    nxt_st = st_ff;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    // Fetch stage, one word per cycle while running
    if (st_ff.run) begin
      nxt_st.ir = prog_data;
      nxt_st.ir_pc = st_ff.pc;
      nxt_st.ir_valid = 1'b1;
      nxt_st.pc = (st_ff.pc + 13'h0001) & PC_MASK;
    end
    // APB setup phase: answer and read data ready for the access phase
    if (psel && !penable) begin
      nxt_st.pready = 1'b1;
      nxt_st.pslverr = (a_kind == APB_BAD);
      nxt_st.prdata = 32'h0000_0000;
      if (a_kind == APB_FILE) begin
        nxt_st.prdata[7:0] = file_rd(st_ff, a_file);
      end else if (a_kind == APB_ACC) begin
        nxt_st.prdata[7:0] = st_ff.w;
      end else if (a_kind == APB_CTRL) begin
        nxt_st.prdata[0] = st_ff.run;
      end
    end
    // APB access phase write
    if (apb_wr) begin
      if (a_kind == APB_FILE) begin
        nxt_st = file_wr(nxt_st, a_file, pwdata[7:0]);
      end else if (a_kind == APB_ACC) begin
        nxt_st.w = pwdata[7:0];
      end else if (a_kind == APB_CTRL) begin
        nxt_st.run = pwdata[0];
      end
    end
    // Execute stage
    if (exec_go) begin
      case (exec_op)
        OP_ALU: begin
          b = op_use_lit ? op_lit : file_rd(st_ff, op_file);
          sub = (alu_op == ALU_SUB);
          wo = sub ? ~st_ff.w : st_ff.w;
          s9 = {1'b0, b} + {1'b0, wo} + {8'h00, sub};
          n5 = {1'b0, b[3:0]} + {1'b0, wo[3:0]} + {4'h0, sub};
          case (alu_op)
            ALU_ADD: res = s9[7:0];
            ALU_SUB: res = s9[7:0];
            ALU_AND: res = b & st_ff.w;
            ALU_IOR: res = b | st_ff.w;
            ALU_XOR: res = b ^ st_ff.w;
            ALU_MOVE: res = b;
            ALU_RLF: res = {b[6:0], st_ff.status[`CPS_ST_C]};
            default: res = {st_ff.status[`CPS_ST_C], b[7:1]};
          endcase
          if (op_to_file) begin
            nxt_st = file_wr(nxt_st, op_file, res);
          end else begin
            nxt_st.w = res;
          end
          // Flags land after the store so they win over a status write
          case (alu_op)
            ALU_ADD, ALU_SUB: begin
              nxt_st.status[`CPS_ST_C] = s9[8];
              nxt_st.status[`CPS_ST_NC] = n5[4];
              nxt_st.status[`CPS_ST_Z] = (res == 8'h00);
            end
            ALU_RLF: nxt_st.status[`CPS_ST_C] = b[7];
            ALU_RRF: nxt_st.status[`CPS_ST_C] = b[0];
            default: nxt_st.status[`CPS_ST_Z] = (res == 8'h00);
          endcase
        end
        OP_CALL: begin
          nxt_st.stack[st_ff.sp] = st_ff.pc;
          nxt_st.sp = sp_step(st_ff.sp, 1'b1);
          nxt_st.pc = call_tgt;
          nxt_st.ir_valid = 1'b0;
        end
        OP_GOTO: begin
          nxt_st.pc = call_tgt;
          nxt_st.ir_valid = 1'b0;
        end
        OP_RETURN, OP_EXIT_LIT, OP_INT_EXIT: begin
          nxt_st.sp = sp_prev;
          nxt_st.pc = stack_top;
          nxt_st.ir_valid = 1'b0;
          if (exec_op == OP_EXIT_LIT) begin
            nxt_st.w = op_lit;
          end
        end
        OP_IRQ: begin
          // The replaced word is re-run after the handler returns
          nxt_st.stack[st_ff.sp] = st_ff.ir_pc;
          nxt_st.sp = sp_step(st_ff.sp, 1'b1);
          nxt_st.pc = `CPS_IRQ_VEC;
          nxt_st.ir_valid = 1'b0;
        end
        default: nxt_st.ir_valid = st_ff.ir_valid;
      endcase
    end
  end

  // State register; reset clears everything including the PC
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.pc <= `CPS_PC_RST;
      st_ff.run <= `CPS_RUN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign prog_addr = st_ff.pc;
  assign instr_word = st_ff.ir;
  assign instr_valid = st_ff.ir_valid;
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;

  // Checks
  default clocking cps_cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence call_seq;
    exec_go && exec_op == OP_CALL;
  endsequence
  sequence ret_seq;
    exec_go && (exec_op == OP_RETURN || exec_op == OP_EXIT_LIT || exec_op == OP_INT_EXIT);
  endsequence
  sequence branch_seq;
    exec_go && exec_op inside {OP_CALL, OP_GOTO, OP_RETURN, OP_EXIT_LIT, OP_INT_EXIT, OP_IRQ};
  endsequence

  reset_clear_a: assert property (disable iff (1'b0) reset |=> st_ff.pc == 13'h0000)
    else $error("PC not cleared by reset");
  call_target_a: assert property (call_seq |=> st_ff.pc == $past(call_tgt))
    else $error("call target wrong");
  call_push_a: assert property (call_seq |=> st_ff.stack[$past(st_ff.sp)] == $past(st_ff.pc))
    else $error("call did not push PC");
  ret_pop_a: assert property (ret_seq |=> st_ff.pc == $past(stack_top) && st_ff.sp == $past(sp_prev))
    else $error("return did not pop");
  uah_hold_a: assert property ((call_seq or ret_seq) and !apb_wr |=> $stable(st_ff.uah))
    else $error("holding register changed by stack");
  stack_wrap_a: assert property (call_seq and st_ff.sp == SPW'(STACK_DEPTH - 1) |=> st_ff.sp == '0)
    else $error("stack did not wrap");
  branch_bubble_a: assert property (branch_seq |=> !st_ff.ir_valid ##1 (st_ff.ir_valid || !st_ff.run))
    else $error("branch bubble wrong");
  fetch_step_a: assert property (st_ff.run && !exec_go && !apb_wr |=> st_ff.pc == $past(st_ff.pc) + 13'h0001)
    else $error("fetch did not advance PC");
  clb_load_a: assert property (apb_wr && paddr == `CPS_A_CLB && !st_ff.run
      |=> st_ff.pc == {$past(st_ff.uah), $past(pwdata[7:0])})
    else $error("low byte write load wrong");
  ind_zero_a: assert property (psel && !penable && !pwrite && paddr == `CPS_A_IND && st_ff.ptr == `CPS_F_IND
      |=> pready && prdata == 32'h0000_0000)
    else $error("self-indirect read not zero");
  ind_nowrite_a: assert property (apb_wr && paddr == `CPS_A_IND && st_ff.ptr == `CPS_F_IND && !st_ff.run
      |=> $stable(st_ff.dmem) && $stable(st_ff.ptr))
    else $error("self-indirect write stored");
  sub_borrow_a: assert property (exec_go && exec_op == OP_ALU && alu_op == ALU_SUB && op_use_lit && !op_to_file
      |=> st_ff.status[`CPS_ST_C] == ($past(op_lit) >= $past(st_ff.w)))
    else $error("subtract borrow wrong");

endmodule // cps_core

/* File: rtl/cps_consts.svh */
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH
// File register addresses seen by executing instructions
`define CPS_F_IND 8'h00
`define CPS_F_CLB 8'h02
`define CPS_F_STATUS 8'h03
`define CPS_F_PTR 8'h04
`define CPS_F_UAH 8'h0A
// Status bit positions
`define CPS_ST_C 0
`define CPS_ST_NC 1
`define CPS_ST_Z 2
`define CPS_ST_BANK 7
// APB byte offsets
`define CPS_A_CLB 8'h00
`define CPS_A_UAH 8'h04
`define CPS_A_PTR 8'h08
`define CPS_A_STATUS 8'h0C
`define CPS_A_ACC 8'h10
`define CPS_A_IND 8'h14
`define CPS_A_CTRL 8'h18
// Reset values and fixed targets
`define CPS_PC_RST 13'h0000
`define CPS_RUN_RST 1'b0
`define CPS_IRQ_VEC 13'h0004
`endif

/* File: rtl/cps_pkg.sv */
package cps_pkg;
  // Decoded class of the executing instruction word
  typedef enum logic [2:0] {
    OP_NONE, OP_ALU, OP_CALL, OP_GOTO, OP_RETURN, OP_EXIT_LIT, OP_INT_EXIT, OP_IRQ
  } cps_op_e;
  // ALU functions
  typedef enum logic [2:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_MOVE, ALU_RLF, ALU_RRF
  } cps_alu_e;
  // APB register classes
  typedef enum logic [1:0] {APB_FILE, APB_ACC, APB_CTRL, APB_BAD} cps_apb_e;
endpackage

/* File: tb/cps_mem_model.sv */
`timescale 1ns/10ps
// Program memory and instruction decoder that stand outside the core
module cps_mem_model (
  input wire logic [12:0] prog_addr,
  output logic [13:0] prog_data,
  input wire logic [13:0] instr_word,
  output cps_pkg::cps_op_e exec_op,
  output cps_pkg::cps_alu_e alu_op,
  output logic [7:0] op_file,
  output logic [7:0] op_lit,
  output logic op_use_lit,
  output logic op_to_file
);
  import cps_pkg::*;
  logic [13:0] words [0:8191];
  // Unwritten words decode as no operation
  initial begin
    for (int i = 0; i < 8192; i++) begin
      words[i] = 14'h0000;
    end
  end
  // Word at the fetch address within the same cycle, on its own bus
  assign prog_data = words[prog_addr];
  // Fields: class 13:11, function 10:8, literal select 7, to file 6, operand 5:0
  always_comb begin
    exec_op = cps_op_e'(instr_word[13:11]);
    alu_op = cps_alu_e'(instr_word[10:8]);
    op_use_lit = instr_word[7];
    op_to_file = instr_word[6];
    op_file = {2'b00, instr_word[5:0]};
    op_lit = {2'b00, instr_word[5:0]};
  end
endmodule // cps_mem_model

/* File: tb/core_pc_stack_indirect_tb.sv */
`timescale 1ns/10ps
`include "cps_consts.svh"
module core_pc_stack_indirect_tb;
  import cps_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] x; logic e;} cps_row_s;
  typedef struct packed {logic [13:0] w; logic [7:0] acc; logic [7:0] xa; logic [7:0] xs;} cps_alu_row_s;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, err, log_on;
  logic instr_valid, op_use_lit, op_to_file;
  logic [7:0] paddr, op_file, op_lit;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] prog_addr;
  logic [13:0] prog_data, instr_word;
  cps_op_e exec_op;
  cps_alu_e alu_op;
  int n_fail, n_compared;
  logic [12:0] seen [$];
  logic [12:0] exp13 [$];
  // Register table walk: writes, read-backs and the unmapped place
  localparam cps_row_s ROWS [13] = '{
    '{1'b1, `CPS_A_PTR, 8'h20, 8'h00, 1'b0}, '{1'b1, `CPS_A_IND, 8'h5A, 8'h00, 1'b0},
    '{1'b0, `CPS_A_IND, 8'h00, 8'h5A, 1'b0}, '{1'b1, `CPS_A_PTR, 8'h00, 8'h00, 1'b0},
    '{1'b1, `CPS_A_IND, 8'h77, 8'h00, 1'b0}, '{1'b0, `CPS_A_IND, 8'h00, 8'h00, 1'b0},
    '{1'b1, `CPS_A_PTR, 8'h20, 8'h00, 1'b0}, '{1'b1, `CPS_A_STATUS, 8'h80, 8'h00, 1'b0},
    '{1'b0, `CPS_A_IND, 8'h00, 8'h5A, 1'b0}, '{1'b1, `CPS_A_UAH, 8'hFF, 8'h00, 1'b0},
    '{1'b0, `CPS_A_UAH, 8'h00, 8'h1F, 1'b0}, '{1'b1, 8'h1C, 8'h55, 8'h00, 1'b1},
    '{1'b0, 8'h1C, 8'h00, 8'h00, 1'b1}};
  // Literal ALU cases: word, accumulator before, result, flags
  localparam cps_alu_row_s ALUS [6] = '{
    '{14'h0888, 8'hF8, 8'h00, 8'h07}, '{14'h0985, 8'h06, 8'hFF, 8'h00},
    '{14'h0988, 8'h03, 8'h05, 8'h03}, '{14'h0AB0, 8'h0F, 8'h00, 8'h04},
    '{14'h0CBF, 8'hC0, 8'hFF, 8'h00}, '{14'h0FA1, 8'h00, 8'h10, 8'h01}};

  cps_core #(.PROG_WORDS(8192)) DUT (.core_clk(core_clk), .reset(reset), .prog_addr(prog_addr),
    .prog_data(prog_data), .instr_word(instr_word), .instr_valid(instr_valid), .exec_op(exec_op),
    .alu_op(alu_op), .op_file(op_file), .op_lit(op_lit), .op_use_lit(op_use_lit), .op_to_file(op_to_file),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  cps_mem_model u_mem (.prog_addr(prog_addr), .prog_data(prog_data), .instr_word(instr_word),
    .exec_op(exec_op), .alu_op(alu_op), .op_file(op_file), .op_lit(op_lit), .op_use_lit(op_use_lit),
    .op_to_file(op_to_file));

  // 100 ns clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Branch targets: fetch address in each flushed cycle while logging, first 19 only
  always @(posedge core_clk) begin
    if (log_on && instr_valid === 1'b0 && seen.size() < 19) seen.push_back(prog_addr);
  end

  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chkv(input string nm, input logic [12:0] x, input logic [12:0] g);
    n_compared++;
    if (g !== x) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic chk1(input string nm, input logic x, input logic g);
    chkv(nm, {12'h000, x}, {12'h000, g});
  endtask

  // One APB transfer after an idle edge; returns at the falling edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int i;
    i = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge core_clk);
    if (i >= 16) begin
      n_fail++;
      finish_test();
    end
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chkv(nm, {5'h00, x}, {5'h00, rd[7:0]});
  endtask

  // Main sequence
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata, log_on, n_fail, n_compared} = '0;
    reset = 1'b1;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chkv("pc after reset", 13'h0000, prog_addr);
    chk1("valid after reset", 1'b0, instr_valid);
    foreach (ROWS[i]) begin
      apb(ROWS[i].wr, ROWS[i].a, ROWS[i].d);
      if (!ROWS[i].wr) chkv("read data", {5'h00, ROWS[i].x}, {5'h00, rd[7:0]});
      chk1("slave error", ROWS[i].e, err);
    end
    apb(1'b1, `CPS_A_UAH, 8'h15);
    apb(1'b1, `CPS_A_CLB, 8'h34);
    chkv("loaded pc", 13'h1534, prog_addr);
    rdchk("low byte", `CPS_A_CLB, 8'h34);
    foreach (ALUS[i]) begin
      u_mem.words[13'h1540 + 13'(4 * i)] = ALUS[i].w;
      apb(1'b1, `CPS_A_ACC, ALUS[i].acc);
      apb(1'b1, `CPS_A_STATUS, 8'h00);
      apb(1'b1, `CPS_A_CLB, 8'(8'h40 + 4 * i));
      apb(1'b1, `CPS_A_CTRL, 8'h01);
      apb(1'b1, `CPS_A_CTRL, 8'h00);
      rdchk("alu result", `CPS_A_ACC, ALUS[i].xa);
      rdchk("alu flags", `CPS_A_STATUS, ALUS[i].xs);
    end
    // Nine nested calls then returns; the ninth push wraps onto the oldest slot
    for (int k = 0; k < 9; k++) begin
      u_mem.words[(k == 0) ? 13'h0F00 : 13'(13'h0800 + 16 * k)] = {OP_CALL, 11'(16 * (k + 1))};
      u_mem.words[13'(13'h0801 + 16 * k)] = {OP_RETURN, 11'h000};
    end
    u_mem.words[13'h0890] = {OP_RETURN, 11'h000};
    exp13.push_back(13'h0F00);
    for (int k = 1; k < 10; k++) exp13.push_back(13'(13'h0800 + 16 * k));
    for (int k = 8; k > 0; k--) exp13.push_back(13'(13'h0801 + 16 * k));
    exp13.push_back(13'h0881);
    apb(1'b1, `CPS_A_UAH, 8'h0F);
    apb(1'b1, `CPS_A_CLB, 8'h00);
    apb(1'b1, `CPS_A_CTRL, 8'h01);
    log_on = 1'b1;
    for (int t = 0; t < 200 && seen.size() < 19; t++) @(negedge core_clk);
    apb(1'b1, `CPS_A_CTRL, 8'h00);
    if (seen.size() != 19) begin
      n_fail++;
      finish_test();
    end
    foreach (exp13[i]) chkv("branch target", exp13[i], seen[i]);
    rdchk("holding kept", `CPS_A_UAH, 8'h0F);
    // Jump, literal return, interrupt entry and its exit
    u_mem.words[13'h0004] = {OP_INT_EXIT, 11'h000};
    u_mem.words[13'h0F40] = {OP_GOTO, 11'h748};
    u_mem.words[13'h0F48] = {OP_CALL, 11'h750};
    u_mem.words[13'h0F49] = {OP_IRQ, 11'h000};
    u_mem.words[13'h0F50] = {OP_EXIT_LIT, 11'h02A};
    log_on = 1'b0;
    seen.delete();
    exp13 = '{13'h0F40, 13'h0F48, 13'h0F50, 13'h0F49, 13'h0004, 13'h0F49};
    apb(1'b1, `CPS_A_CLB, 8'h40);
    apb(1'b1, `CPS_A_CTRL, 8'h01);
    log_on = 1'b1;
    for (int t = 0; t < 100 && seen.size() < 6; t++) @(negedge core_clk);
    apb(1'b1, `CPS_A_CTRL, 8'h00);
    if (seen.size() < 6) begin
      n_fail++;
      finish_test();
    end
    foreach (exp13[i]) chkv("jump target", exp13[i], seen[i]);
    rdchk("literal return", `CPS_A_ACC, 8'h2A);
    // Reset in mid-run
    apb(1'b1, `CPS_A_CTRL, 8'h01);
    repeat (3) @(posedge core_clk);
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    chkv("pc after second reset", 13'h0000, prog_addr);
    chk1("word after reset", 1'b0, |instr_word);
    rdchk("run after reset", `CPS_A_CTRL, 8'h00);
    finish_test();
  end
endmodule // core_pc_stack_indirect_tb
